// ### smb_link.sv
`timescale 1ns/1ps
module smb_link
  import smb_pkg::*;
(
  input wire logic scl_clk_i,
  input wire logic sda_i,
  smb_link_if.lnk lk
);

  typedef struct packed {
    smb_lmode_e mode;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic rw;
    logic ack_go;
    logic wr_tgl;
    logic wr_kind;
    logic [7:0] wr_byte;
    logic [1:0] a1;
    logic [1:0] a2;
    logic f1;
    logic f2;
  } smb_lpos_s;

  typedef struct packed {
    logic oe;
    logic [7:0] tx;
    logic rd_tgl;
  } smb_lneg_s;

  smb_lpos_s pos_r;
  smb_lpos_s pos_nxt;
  smb_lneg_s neg_r;
  smb_lneg_s neg_nxt;
  logic [7:0] rx_byte;

  always_comb begin
    pos_nxt = pos_r;
    rx_byte = {pos_r.sh[6:0], sda_i};
    pos_nxt.a1 = lk.addr_lsb;
    pos_nxt.a2 = pos_r.a1;
    pos_nxt.f1 = lk.refuse;
    pos_nxt.f2 = pos_r.f1;
    if (pos_r.bitcnt != ACK_SLOT) begin
      pos_nxt.sh = rx_byte;
      pos_nxt.bitcnt = pos_r.bitcnt + 4'h1;
      if (pos_r.bitcnt == LAST_BIT) begin
        pos_nxt.ack_go = 1'b0;
        case (pos_r.mode)
          LM_ADDR: begin
            if (rx_byte[7:1] == {SLV_ADDR_HI5, pos_r.a2}) begin
              pos_nxt.ack_go = 1'b1;
              pos_nxt.rw = rx_byte[0];
              if (!rx_byte[0]) begin
                pos_nxt.wr_tgl = ~pos_r.wr_tgl;
                pos_nxt.wr_kind = EV_KIND_ADDR;
              end
            end
          end
          LM_WR: begin
            // A refused byte is not acknowledged and not passed on
            pos_nxt.ack_go = ~pos_r.f2;
            if (!pos_r.f2) begin
              pos_nxt.wr_tgl = ~pos_r.wr_tgl;
              pos_nxt.wr_kind = EV_KIND_DATA;
              pos_nxt.wr_byte = rx_byte;
            end
          end
          default: ;
        endcase
      end
    end else begin
      pos_nxt.bitcnt = 4'h0;
      pos_nxt.ack_go = 1'b0;
      case (pos_r.mode)
        LM_ADDR: pos_nxt.mode = pos_r.ack_go ? (pos_r.rw ? LM_RD : LM_WR) : LM_IDLE;
        LM_RD: if (sda_i) pos_nxt.mode = LM_IDLE;
        default: ;
      endcase
    end
  end

  always_ff @(posedge scl_clk_i or negedge lk.link_rst_n) begin
    if (!lk.link_rst_n) begin
      pos_r <= '{mode: LM_ADDR, bitcnt: 4'h0, sh: 8'h00, rw: 1'b0, ack_go: 1'b0, wr_tgl: 1'b0,
                 wr_kind: EV_KIND_ADDR, wr_byte: 8'h00, a1: STRAP_OPEN_BITS, a2: STRAP_OPEN_BITS,
                 f1: 1'b0, f2: 1'b0};
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // Data line moves only on the falling clock edge
  always_comb begin
    neg_nxt = neg_r;
    neg_nxt.oe = 1'b0;
    if (pos_r.bitcnt == ACK_SLOT) begin
      neg_nxt.oe = pos_r.ack_go;
    end else if (pos_r.mode == LM_RD) begin
      if (pos_r.bitcnt == 4'h0) begin
        // Loading advances the pointer early so the next byte is ready in time
        neg_nxt.tx = lk.rd_data;
        neg_nxt.oe = ~lk.rd_data[7];
        neg_nxt.rd_tgl = ~neg_r.rd_tgl;
      end else begin
        neg_nxt.oe = ~neg_r.tx[3'(LAST_BIT - pos_r.bitcnt)];
      end
    end
  end

  always_ff @(negedge scl_clk_i or negedge lk.link_rst_n) begin
    if (!lk.link_rst_n) begin
      neg_r <= '{oe: 1'b0, tx: 8'h00, rd_tgl: 1'b0};
    end else begin
      neg_r <= neg_nxt;
    end
  end

  assign lk.wr_tgl = pos_r.wr_tgl;
  assign lk.wr_kind = pos_r.wr_kind;
  assign lk.wr_byte = pos_r.wr_byte;
  assign lk.rd_tgl = neg_r.rd_tgl;
  assign lk.sda_oe = neg_r.oe;

endmodule

// ### smb_link_if.sv
`timescale 1ns/1ps
interface smb_link_if;
  logic link_rst_n;
  logic [1:0] addr_lsb;
  logic refuse;
  logic [7:0] rd_data;
  logic wr_tgl;
  logic wr_kind;
  logic [7:0] wr_byte;
  logic rd_tgl;
  logic sda_oe;

  modport eng (
    output link_rst_n, addr_lsb, refuse, rd_data,
    input wr_tgl, wr_kind, wr_byte, rd_tgl, sda_oe
  );
  modport lnk (
    input link_rst_n, addr_lsb, refuse, rd_data,
    output wr_tgl, wr_kind, wr_byte, rd_tgl, sda_oe
  );
endinterface

// ### smb_master_model.sv
`timescale 1ns/1ps
module smb_master_model (
  output logic scl_o,
  output logic pull_o,
  input wire logic sda_i
);
  // Only a pull is modelled: a released line floats to the pull-up level
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // Data moves mid-way through the low phase, sampled mid-way through high
  task automatic pulse(input logic b, output logic r);
    pull_o = ~b;
    #36 scl_o = 1'b1;
    #36 r = sda_i;
    #36 scl_o = 1'b0;
    #36;
  endtask

  task automatic start();
    pull_o = 1'b0;
    #36 scl_o = 1'b1;
    #72 pull_o = 1'b1;
    #72 scl_o = 1'b0;
    #36;
  endtask

  task automatic stop();
    pull_o = 1'b1;
    #36 scl_o = 1'b1;
    #72 pull_o = 1'b0;
    #72;
  endtask

  // Ninth bit: 1 listens for an acknowledge, 0 gives one
  task automatic xfer(input logic [7:0] d, input logic nb, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(d[i], s);
      r[i] = s;
    end
    pulse(nb, s);
    ack = ~s;
  endtask
endmodule

// ### smb_pkg.sv
package smb_pkg;

  // Fixed upper part of the 7-bit slave address
  localparam logic [4:0] SLV_ADDR_HI5 = 5'h0B;

  // Decoded strap bits {high, low}
  localparam logic [1:0] STRAP_GND_BITS = 2'h0;
  localparam logic [1:0] STRAP_OPEN_BITS = 2'h2;
  localparam logic [1:0] STRAP_VCC_BITS = 2'h1;

  // Address map
  localparam logic [7:0] RAM_LAST = 8'h6F;
  localparam int RAM_DEPTH = 112;
  localparam logic [15:0] NVM_FIRST = 16'h8000;
  localparam logic [15:0] NVM_LAST = 16'h9FFF;
  localparam int NVM_DEPTH = 8192;
  localparam logic [2:0] NVM_HI_TAG = 3'h4;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // Command and memory values
  localparam logic [7:0] BLK_WR_CMD = 8'hA0;
  localparam logic [7:0] NVM_BLANK = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [6:0] USER_PAGES = 7'h7C;
  localparam logic [5:0] PAGE_LAST_BYTE = 6'h3F;

  // Bit slots within a nine-clock frame
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Byte position within a write
  localparam logic [1:0] IDX_CMD = 2'h0;
  localparam logic [1:0] IDX_AUX = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;

  // Kind of byte event passed from the link
  localparam logic EV_KIND_ADDR = 1'b0;
  localparam logic EV_KIND_DATA = 1'b1;

  typedef enum logic [1:0] {
    LM_ADDR = 2'b00,
    LM_WR = 2'b01,
    LM_RD = 2'b11,
    LM_IDLE = 2'b10
  } smb_lmode_e;

endpackage

// ### smb_port_monitor.sv
`timescale 1ns/1ps
module smb_port_monitor
  import smb_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic nvm_erase_mode_i,
  input wire logic addr_locked_o,
  input wire logic frame_active_o,
  input wire logic nvm_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  logic [7:0] busy_cnt_r;
  logic [7:0] busy_cnt_nxt;
  always_comb busy_cnt_nxt = nvm_busy_o ? busy_cnt_r + 8'h01 : 8'h00;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) busy_cnt_r <= 8'h00;
    else busy_cnt_r <= busy_cnt_nxt;
  end

  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  sequence s_ack_high;
    $rose(scl_i) && sda_oe_o;
  endsequence

  chk_sda_open: assert property (sda_o == 1'b0) else $error("data pin value not low");
  chk_oe_change: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
  chk_ack_holds: assert property (s_ack_high |-> sda_oe_o [*5]) else $error("pull dropped, clock high");
  chk_oe_in_frame: assert property (sda_oe_o |-> frame_active_o) else $error("pull outside frame");
  chk_lock_start: assert property (s_start ##0 !addr_locked_o |-> ##[1:8] addr_locked_o) else $error("no lock");
  chk_lock_keep: assert property (addr_locked_o |=> addr_locked_o) else $error("lock lost");
  chk_erase_len: assert property ($fell(nvm_busy_o) |-> busy_cnt_r == 8'h40) else $error("erase length");
  chk_erase_cause: assert property ($rose(nvm_busy_o) |-> frame_active_o && nvm_erase_mode_i) else $error("stray erase");
endmodule

bind smb_slave_port smb_port_monitor mon (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .nvm_erase_mode_i(nvm_erase_mode_i), .addr_locked_o(addr_locked_o),
  .frame_active_o(frame_active_o), .nvm_busy_o(nvm_busy_o));

// ### smb_slave_port.sv
`timescale 1ns/1ps
module smb_slave_port
  import smb_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic slave_addr_strap_pin_vcc_i,
  input wire logic slave_addr_strap_pin_gnd_i,
  input wire logic nvm_erase_mode_i,
  output logic addr_locked_o,
  output logic frame_active_o,
  output logic nvm_busy_o
);

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] ers_s;
    logic scl_f;
    logic sda_f;
    logic ers_f;
    logic [2:0] wt;
    logic [2:0] rt;
    logic frame;
    logic hold;
    logic lock_pls;
    logic [15:0] ptr;
    logic [7:0] hi;
    logic [1:0] idx;
    logic blk;
    logic nvsel;
    logic refuse;
    logic [7:0] rd_data;
    logic busy;
    logic [6:0] epage;
    logic [5:0] ecnt;
  } smb_main_s;

  smb_main_s eng_r;
  smb_main_s eng_nxt;

  logic [7:0] ram_mem [0:RAM_DEPTH-1];
  logic [7:0] nvm_mem [0:NVM_DEPTH-1];

  logic ram_we;
  logic [6:0] ram_wa;
  logic [7:0] ram_wd;
  logic nvm_we;
  logic [12:0] nvm_wa;
  logic [7:0] nvm_wd;

  logic in_ram;
  logic in_nvm;
  logic [7:0] nvm_at_ptr;
  logic start_det;
  logic stop_det;
  logic wr_ev;
  logic rd_ev;
  logic strap_hi;
  logic strap_lo;
  logic strap_locked;

  smb_link_if lk ();

  smb_link u_link (
    .scl_clk_i(scl_clk_i),
    .sda_i(sda_i),
    .lk(lk.lnk)
  );

  smb_strap u_strap (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_vcc_i(slave_addr_strap_pin_vcc_i),
    .pin_gnd_i(slave_addr_strap_pin_gnd_i),
    .lock_i(eng_r.lock_pls),
    .strap_addr_bit_high_o(strap_hi),
    .strap_addr_bit_low_o(strap_lo),
    .locked_o(strap_locked)
  );

  assign in_ram = (eng_r.ptr[15:8] == 8'h00) && (eng_r.ptr[7:0] <= RAM_LAST);
  assign in_nvm = (eng_r.ptr[15:13] == NVM_HI_TAG);
  assign nvm_at_ptr = nvm_mem[eng_r.ptr[12:0]];

  always_comb begin
    eng_nxt = eng_r;
    ram_we = 1'b0;
    ram_wa = eng_r.ptr[6:0];
    ram_wd = lk.wr_byte;
    nvm_we = 1'b0;
    nvm_wa = eng_r.ptr[12:0];
    nvm_wd = lk.wr_byte;
    eng_nxt.lock_pls = 1'b0;

    // Bus pins are filtered: a level counts once two samples agree
    eng_nxt.scl_s = {eng_r.scl_s[1:0], scl_i};
    eng_nxt.sda_s = {eng_r.sda_s[1:0], sda_i};
    eng_nxt.ers_s = {eng_r.ers_s[1:0], nvm_erase_mode_i};
    if (eng_r.scl_s[1] == eng_r.scl_s[2]) begin
      eng_nxt.scl_f = eng_r.scl_s[2];
    end
    if (eng_r.sda_s[1] == eng_r.sda_s[2]) begin
      eng_nxt.sda_f = eng_r.sda_s[2];
    end
    if (eng_r.ers_s[1] == eng_r.ers_s[2]) begin
      eng_nxt.ers_f = eng_r.ers_s[2];
    end
    start_det = eng_r.scl_f && eng_nxt.scl_f && eng_r.sda_f && !eng_nxt.sda_f;
    stop_det = eng_r.scl_f && eng_nxt.scl_f && !eng_r.sda_f && eng_nxt.sda_f;

    // Link events arrive as toggles; byte and kind stay put for a full frame
    eng_nxt.wt = {eng_r.wt[1:0], lk.wr_tgl};
    eng_nxt.rt = {eng_r.rt[1:0], lk.rd_tgl};
    // Holding the link clears its toggles, which would look like one more event;
    // the hold outlasts the synchroniser delay, so events seen during it are dropped
    wr_ev = (eng_r.wt[1] ^ eng_r.wt[2]) && !eng_r.hold;
    rd_ev = (eng_r.rt[1] ^ eng_r.rt[2]) && !eng_r.hold;

    // The link logic is held in reset outside frames and across a start,
    // and released only while the clock is low so no edge races it
    if (start_det) begin
      eng_nxt.frame = 1'b1;
      eng_nxt.hold = 1'b1;
      if (!strap_locked) begin
        eng_nxt.lock_pls = 1'b1;
      end
    end else if (stop_det) begin
      eng_nxt.frame = 1'b0;
      eng_nxt.hold = 1'b1;
    end else if (eng_r.frame && eng_r.hold && !eng_r.scl_f) begin
      eng_nxt.hold = 1'b0;
    end

    if (wr_ev) begin
      if (lk.wr_kind == EV_KIND_ADDR) begin
        eng_nxt.idx = IDX_CMD;
        eng_nxt.blk = 1'b0;
        eng_nxt.nvsel = 1'b0;
      end else begin
        case (eng_r.idx)
          IDX_CMD: begin
            if (lk.wr_byte == BLK_WR_CMD) begin
              eng_nxt.blk = 1'b1;
              eng_nxt.idx = IDX_AUX;
            end else if (lk.wr_byte[7:5] == NVM_HI_TAG) begin
              eng_nxt.hi = lk.wr_byte;
              eng_nxt.nvsel = 1'b1;
              eng_nxt.idx = IDX_AUX;
            end else begin
              // Alone, this byte still sets the next access address
              eng_nxt.ptr = {8'h00, lk.wr_byte};
              eng_nxt.idx = IDX_DATA;
            end
          end
          IDX_AUX: begin
            // Block count is taken but not checked against the data sent
            if (!eng_r.blk) begin
              eng_nxt.ptr = {eng_r.hi, lk.wr_byte};
            end
            eng_nxt.idx = IDX_DATA;
          end
          default: begin
            if (in_ram) begin
              ram_we = 1'b1;
            end else if (in_nvm && !eng_r.busy) begin
              if (eng_r.ers_f) begin
                // Reserved top pages are never erased
                if (eng_r.ptr[12:6] < USER_PAGES) begin
                  eng_nxt.busy = 1'b1;
                  eng_nxt.epage = eng_r.ptr[12:6];
                  eng_nxt.ecnt = 6'h00;
                end
              end else if (nvm_at_ptr == NVM_BLANK) begin
                nvm_we = 1'b1;
              end
            end
            eng_nxt.ptr = eng_r.ptr + 16'h0001;
          end
        endcase
      end
    end else if (rd_ev) begin
      eng_nxt.ptr = eng_r.ptr + 16'h0001;
    end

    // Page erase walks one byte per cycle; nonvolatile writes are refused meanwhile, reads are still served
    if (eng_r.busy) begin
      nvm_we = 1'b1;
      nvm_wa = {eng_r.epage, eng_r.ecnt};
      nvm_wd = NVM_BLANK;
      eng_nxt.ecnt = eng_r.ecnt + 6'h01;
      if (eng_r.ecnt == PAGE_LAST_BYTE) begin
        eng_nxt.busy = 1'b0;
      end
    end

    // Decided a byte ahead, since the answer is due before this side could react
    eng_nxt.refuse = (eng_r.idx == IDX_DATA) && in_nvm &&
                     (eng_r.busy || (!eng_r.ers_f && nvm_at_ptr != NVM_BLANK));

    if (in_ram) begin
      eng_nxt.rd_data = ram_mem[eng_r.ptr[6:0]];
    end else if (in_nvm) begin
      eng_nxt.rd_data = nvm_at_ptr;
    end else begin
      eng_nxt.rd_data = RD_UNMAPPED;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eng_r <= '{scl_s: 3'h7, sda_s: 3'h7, ers_s: 3'h0, scl_f: 1'b1, sda_f: 1'b1, ers_f: 1'b0,
                 wt: 3'h0, rt: 3'h0, frame: 1'b0, hold: 1'b1, lock_pls: 1'b0, ptr: PTR_RST,
                 hi: 8'h00, idx: IDX_CMD, blk: 1'b0, nvsel: 1'b0, refuse: 1'b0,
                 rd_data: RD_UNMAPPED, busy: 1'b0, epage: 7'h00, ecnt: 6'h00};
    end else begin
      eng_r <= eng_nxt;
    end
  end

  // Volatile registers lose contents only on power loss, not on this reset
  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      ram_mem[ram_wa] <= ram_wd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (nvm_we) begin
      nvm_mem[nvm_wa] <= nvm_wd;
    end
  end

  assign lk.link_rst_n = ~eng_r.hold;
  assign lk.addr_lsb = {strap_hi, strap_lo};
  assign lk.refuse = eng_r.refuse;
  assign lk.rd_data = eng_r.rd_data;

  // Open-drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = lk.sda_oe;
  assign addr_locked_o = strap_locked;
  assign frame_active_o = eng_r.frame;
  assign nvm_busy_o = eng_r.busy;

endmodule

// ### smb_slave_port_bench.sv
`timescale 1ns/1ps
module smb_slave_port_bench;
  import smb_pkg::*;
  localparam logic [7:0] W = 8'h5C;
  localparam logic [7:0] R = 8'h5D;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic strap_vcc = 1'b0;
  logic strap_gnd = 1'b0;
  logic erase_mode = 1'b0;
  logic scl;
  logic pull;
  logic sda_oe;
  logic locked;
  logic busy;
  logic frame;
  wire logic sda = ~(pull | sda_oe);
  int failures = 0;
  int n_tests = 0;
  logic [7:0] rd;
  logic ack;
  logic s;

  always #5 clk_i = ~clk_i;

  smb_slave_port uut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_clk_i(scl), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .slave_addr_strap_pin_vcc_i(strap_vcc), .slave_addr_strap_pin_gnd_i(strap_gnd),
    .nvm_erase_mode_i(erase_mode), .addr_locked_o(locked), .frame_active_o(frame), .nvm_busy_o(busy));
  smb_master_model m (.scl_o(scl), .pull_o(pull), .sda_i(sda));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset(input logic vcc, input logic gnd);
    @(posedge clk_i) #1;
    nrst_i = 1'b0;
    strap_vcc = vcc;
    strap_gnd = gnd;
    repeat (6) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic put(input logic [7:0] d, input logic exp_ack);
    m.xfer(d, 1'b1, rd, ack);
    check("ack", {7'h00, ack}, {7'h00, exp_ack});
  endtask

  task automatic wr(input logic [7:0] q[$], input logic last_ack, input logic fin);
    m.start();
    put(W, 1'b1);
    foreach (q[i]) put(q[i], (i < q.size() - 1) || last_ack);
    if (fin) m.stop();
  endtask

  task automatic rdq(input logic [7:0] q[$]);
    m.start();
    put(R, 1'b1);
    foreach (q[i]) begin
      m.xfer(8'hFF, i == q.size() - 1, rd, ack);
      check("read byte", rd, q[i]);
    end
    m.stop();
  endtask

  task automatic t_strap();
    logic [1:0] bits [3] = '{STRAP_GND_BITS, STRAP_OPEN_BITS, STRAP_VCC_BITS};
    for (int i = 0; i < 3; i++) begin
      do_reset(i == 2, i == 0);
      m.start();
      put({SLV_ADDR_HI5, bits[i], 1'b0}, 1'b1);
      check("frame", {7'h00, frame}, 8'h01);
      m.stop();
      check("locked", {7'h00, locked}, 8'h01);
    end
    @(posedge clk_i) #1;
    strap_vcc = 1'b0;
    strap_gnd = 1'b1;
    m.start();
    put({SLV_ADDR_HI5, STRAP_GND_BITS, 1'b0}, 1'b0);
    put(8'h00, 1'b0);
    m.stop();
    m.start();
    put({SLV_ADDR_HI5, STRAP_VCC_BITS, 1'b0}, 1'b1);
    m.stop();
    do_reset(1'b0, 1'b0);
  endtask

  task automatic t_ram();
    wr({8'h10, 8'h5A, 8'hA5}, 1'b1, 1'b1);
    wr({8'h6F, 8'h3C}, 1'b1, 1'b1);
    // Pointer set alone, then read behind a repeated start
    wr({8'h10}, 1'b1, 1'b0);
    rdq({8'h5A, 8'hA5});
    wr({8'h6F}, 1'b1, 1'b0);
    rdq({8'h3C, RD_UNMAPPED});
    // A one-byte read leaves the pointer on the next byte for a later read
    wr({8'h10}, 1'b1, 1'b0);
    rdq({8'h5A});
    rdq({8'hA5});
  endtask

  task automatic t_abort();
    wr({8'h20, 8'h77}, 1'b1, 1'b1);
    wr({8'h20}, 1'b1, 1'b0);
    repeat (4) m.pulse(1'b0, s);
    m.stop();
    check("frame", {7'h00, frame}, 8'h00);
    wr({8'h20}, 1'b1, 1'b1);
    rdq({8'h77});
  endtask

  task automatic t_nvm();
    @(posedge clk_i) #1;
    erase_mode = 1'b1;
    wr({8'h80, 8'h00, 8'h11}, 1'b1, 1'b1);
    @(posedge clk_i) #1;
    erase_mode = 1'b0;
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk_i);
    check("erase busy", {7'h00, busy}, 8'h00);
    wr({8'h80, 8'h00}, 1'b1, 1'b0);
    rdq({NVM_BLANK, NVM_BLANK});
    wr({8'h80, 8'h00, 8'h3C}, 1'b1, 1'b1);
    wr({8'h80, 8'h00, 8'hC3}, 1'b0, 1'b1);
    wr({8'h80, 8'h00}, 1'b1, 1'b0);
    rdq({8'h3C});
  endtask

  initial begin
    #900000;
    failures++;
    report_and_stop();
  end

  initial begin
    do_reset(1'b0, 1'b0);
    t_strap();
    t_ram();
    t_abort();
    t_nvm();
    report_and_stop();
  end
endmodule

// ### smb_strap.sv
`timescale 1ns/1ps
module smb_strap
  import smb_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pin_vcc_i,
  input wire logic pin_gnd_i,
  input wire logic lock_i,
  output logic strap_addr_bit_high_o,
  output logic strap_addr_bit_low_o,
  output logic locked_o
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] stable;
    logic locked;
    logic [1:0] bits;
  } smb_strap_s;

  smb_strap_s strap_r;
  smb_strap_s strap_nxt;
  logic [1:0] dec;

  always_comb begin
    strap_nxt = strap_r;
    strap_nxt.s1 = {pin_vcc_i, pin_gnd_i};
    strap_nxt.s2 = strap_r.s1;
    strap_nxt.s3 = strap_r.s2;
    if (strap_r.s2 == strap_r.s3) begin
      strap_nxt.stable = strap_r.s3;
    end
    // A pin seen neither high nor low is floating
    case (strap_r.stable)
      2'h2: dec = STRAP_VCC_BITS;
      2'h1: dec = STRAP_GND_BITS;
      2'h0: dec = STRAP_OPEN_BITS;
      default: dec = STRAP_GND_BITS;
    endcase
    // Caught once, never again until the next reset
    if (lock_i && !strap_r.locked) begin
      strap_nxt.bits = dec;
      strap_nxt.locked = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_r <= '{s1: 2'h0, s2: 2'h0, s3: 2'h0, stable: 2'h0, locked: 1'b0, bits: STRAP_OPEN_BITS};
    end else begin
      strap_r <= strap_nxt;
    end
  end

  assign strap_addr_bit_high_o = strap_r.bits[1];
  assign strap_addr_bit_low_o = strap_r.bits[0];
  assign locked_o = strap_r.locked;

endmodule
